// [rtl/flash_pm_pkg.sv]
// flash power-mode control: shared constants and types
// assumes one core clock at 40 MHz; the link clock is sampled, never used as a clock
// ----------------------------------------------------------------------------
// Contract
// RULE1 - deep sleep refuses write, program, erase
// RULE2 - deselect without busy gives standby
// RULE3 - deep sleep only by sleep instruction
// RULE4 - deep sleep ignores all but wake
// RULE5 - power-up always lands in standby
// RULE6 - sleep code is eight bits, then deselect
// RULE7 - sleep entry waits fixed delay after deselect
// RULE8 - sleep instruction rejected while busy
// RULE9 - wake rejected on extra clocks
// RULE10 - standby after wake delay elapses
// RULE11 - host stays deselected during wake delay
// RULE12 - wake instruction rejected while busy
// RULE13 - host deselected until supply plus 30 us
// RULE14 - below inhibit threshold logic held reset
// RULE15 - write-type instructions locked out after power-up
// RULE16 - host waits later of both delays
// RULE17 - reads accepted after select delay
// RULE18 - power-up standby with write latch cleared
// RULE19 - host may hold reset through power phases
// RULE20 - delivered state: FFh array, zero status
// RULE21 - busy flag high during self-timed cycle
// RULE22 - write-unlock sets write latch
// RULE23 - opcodes and delays are parameters
// RULE24 - msb first on rising clock, recount
// ----------------------------------------------------------------------------
package flash_pm_pkg;
  localparam int          CLK_MHZ            = 40;
  localparam logic [7:0]  SLEEP_OPC          = 8'hb9;
  localparam logic [7:0]  WAKE_OPC           = 8'hab;
  localparam logic [7:0]  UNLOCK_OPC         = 8'h06;
  localparam logic [7:0]  REWRITE_OPC        = 8'h0a;
  localparam logic [7:0]  PROGRAM_OPC        = 8'h02;
  localparam logic [7:0]  PAGE_CLR_OPC       = 8'hdb;
  localparam logic [7:0]  BLOCK_CLR_OPC      = 8'hd8;
  localparam logic [7:0]  READ_OPC           = 8'h03;
  localparam int          SLEEP_ENTRY_NS     = 3000;
  localparam int          WAKE_NS            = 3000;
  localparam int          SELECT_DELAY_US    = 30;
  localparam int          LOCKOUT_US         = 1000;
  localparam int          BUSY_NS            = 10000;
  localparam int          SLEEP_ENTRY_CYC    = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int          WAKE_CYC           = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int          SELECT_DELAY_CYC   = SELECT_DELAY_US * CLK_MHZ;
  localparam int          LOCKOUT_CYC        = LOCKOUT_US * CLK_MHZ;
  localparam int          BUSY_CYC           = (BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int          HALF_SCK_CYC       = 4;
  localparam logic [3:0]  BITS_PER_CODE      = 4'h8;

  typedef enum logic [1:0] {
    PM_STANDBY  = 2'b00,
    PM_ENTERING = 2'b01,
    PM_SLEEP    = 2'b11,
    PM_WAKING   = 2'b10
  } pm_state_e;

  function automatic logic is_write_type(input logic [7:0] opc);
    return (opc == UNLOCK_OPC) || (opc == REWRITE_OPC) || (opc == PROGRAM_OPC) ||
           (opc == PAGE_CLR_OPC) || (opc == BLOCK_CLR_OPC);
  endfunction
endpackage

// [rtl/flash_link_if.sv]
// serial link between host controller and flash power-mode end
// assumes both ends share core_clk; the bench joins them
interface flash_link_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic reset_n;
  modport host_end  (output sel_n, output sclk, output sdi, output reset_n);
  modport flash_end (input sel_n, input sclk, input sdi, input reset_n);
endinterface

// [rtl/sync_delay_cnt.sv]
// down counter that reports when a loaded delay has elapsed
// assumes load and load_val come from the core clock domain
module sync_delay_cnt #(
  parameter int LEN = 16
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic load,
  input  wire logic [LEN-1:0] load_val,
  output logic      done
);
  logic [LEN-1:0] cnt_ff;
  if (LEN < 1) begin : g_bad_len
    $error("LEN too small");
  end
  assign done = (cnt_ff == '0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) cnt_ff <= '0;
    else if (load) cnt_ff <= load_val;
    else if (!done) cnt_ff <= cnt_ff - 1'b1;
  end
endmodule

// [rtl/flash_pm_dev.sv]
// flash end: decodes instructions, runs power modes and power-up lockout
// assumes rst is the power-on reset, high while supply is below threshold
module flash_pm_dev
  import flash_pm_pkg::*;
#(
  parameter logic [7:0] SLEEP_CODE   = SLEEP_OPC, // RULE23
  parameter logic [7:0] WAKE_CODE    = WAKE_OPC,
  parameter int         ENTRY_CYC    = SLEEP_ENTRY_CYC,
  parameter int         WAKE_D_CYC   = WAKE_CYC,
  parameter int         LOCK_CYC     = LOCKOUT_CYC,
  parameter int         SEL_CYC      = SELECT_DELAY_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  flash_link_if.flash_end link,
  input  wire logic busy_done,
  output logic      sleeping,
  output logic      standby,
  output logic      busy_flag,
  output logic      write_latch_flag,
  output logic      lockout,
  output logic      read_ok,
  output logic      write_accept,
  output logic      read_accept
);
  // ---------------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------------
  // a zero delay would leave the timers done from the start
  if (ENTRY_CYC < 1 || WAKE_D_CYC < 1) begin : g_bad_pm_delay
    $error("sleep entry and wake delays need at least one cycle");
  end
  if (LOCK_CYC < 1 || SEL_CYC < 1) begin : g_bad_pu_delay
    $error("power-up delays need at least one cycle");
  end
  // equal codes would let one frame both enter and leave sleep
  if (SLEEP_CODE == WAKE_CODE) begin : g_bad_codes
    $error("sleep and wake codes must differ");
  end

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  // pin order: reset_n, sdi, sclk, sel_n; reset to idle levels so no false edge follows reset
  localparam int         PIN_N    = 4;
  localparam logic [3:0] PIN_IDLE = 4'h1;
  wire  [3:0] pin_raw = {link.reset_n, link.sdi, link.sclk, link.sel_n};
  wire  [3:0] pin_syn;
  logic       sck_d_ff, sel_d_ff;
  for (genvar p = 0; p < PIN_N; p++) begin : g_sync
    logic [1:0] s_ff;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) s_ff <= {2{PIN_IDLE[p]}};
      else     s_ff <= {s_ff[0], pin_raw[p]};
    end
    assign pin_syn[p] = s_ff[1];
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_d_ff <= 1'b0;
      sel_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= pin_syn[1];
      sel_d_ff <= pin_syn[0];
    end
  end
  wire sel_n    = pin_syn[0];
  wire sdi_syn  = pin_syn[2];
  wire sck_rise = pin_syn[1] & ~sck_d_ff;
  wire sel_fall = ~sel_n & sel_d_ff;
  wire sel_rise = sel_n & ~sel_d_ff;
  // host-held reset input acts as an extra reset of the power mode and write latch
  wire hold_rst = ~pin_syn[3]; // RULE19

  // ---------------------------------------------------------------------------
  // instruction shift
  // ---------------------------------------------------------------------------
  logic [7:0] code_ff;
  logic [3:0] bits_ff;
  wire  [7:0] nxt_code = {code_ff[6:0], sdi_syn};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_ff <= 8'h00;
      bits_ff <= 4'h0;
    end else if (sel_fall) begin
      bits_ff <= 4'h0; // RULE24
    end else if (!sel_n && sck_rise) begin
      code_ff <= nxt_code; // RULE24
      if (bits_ff != '1) bits_ff <= bits_ff + 4'h1;
    end
  end
  // exact eight clocks: longer frames are not executed, except a read, which is taken at its eighth rise
  wire exact8   = (bits_ff == BITS_PER_CODE);
  wire got_code = sel_rise && exact8; // RULE6 RULE9
  wire is_sleep = got_code && (code_ff == SLEEP_CODE);
  wire is_wake  = got_code && (code_ff == WAKE_CODE);
  wire is_wtype = got_code && is_write_type(code_ff);
  wire is_read  = !sel_n && sck_rise && (bits_ff == (BITS_PER_CODE - 4'h1)) && (nxt_code == READ_OPC);

  // ---------------------------------------------------------------------------
  // power-up timers
  // ---------------------------------------------------------------------------
  logic lock_done, sel_done, first_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) first_ff <= 1'b1;
    else     first_ff <= 1'b0;
  end
  sync_delay_cnt #(.LEN(32)) u_lock (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (first_ff),
    .load_val (32'(LOCK_CYC)),
    .done     (lock_done)
  );
  sync_delay_cnt #(.LEN(32)) u_sel (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (first_ff),
    .load_val (32'(SEL_CYC)),
    .done     (sel_done)
  );
  assign lockout = first_ff | ~lock_done; // RULE15
  assign read_ok = ~first_ff & sel_done;  // RULE17

  // ---------------------------------------------------------------------------
  // power mode machine
  // ---------------------------------------------------------------------------
  pm_state_e st_ff, nxt_st;
  logic      pm_load, pm_done;
  logic [31:0] pm_val;
  sync_delay_cnt #(.LEN(32)) u_pm (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (pm_load),
    .load_val (pm_val),
    .done     (pm_done)
  );
  logic wl_ff, busy_ff;
  always_comb begin
    nxt_st  = st_ff;
    pm_load = 1'b0;
    pm_val  = 32'(ENTRY_CYC);
    case (st_ff)
      PM_STANDBY: begin
        if (is_sleep && !busy_ff) begin // RULE3 RULE8
          nxt_st  = PM_ENTERING;
          pm_load = 1'b1; // RULE7
        end
      end
      PM_ENTERING: if (pm_done) nxt_st = PM_SLEEP; // RULE7
      PM_SLEEP: begin
        if (is_wake && !busy_ff) begin // RULE4 RULE12
          nxt_st  = PM_WAKING;
          pm_load = 1'b1;
          pm_val  = 32'(WAKE_D_CYC);
        end
      end
      PM_WAKING: if (pm_done) nxt_st = PM_STANDBY; // RULE10
      default: nxt_st = PM_STANDBY;
    endcase
    if (hold_rst) nxt_st = PM_STANDBY;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) st_ff <= PM_STANDBY; // RULE5 RULE14 RULE18
    else     st_ff <= nxt_st;
  end
  wire awake = (st_ff == PM_STANDBY);
  // sleep state ignores write-type codes, acting as software protection
  assign write_accept = is_wtype && awake && !lockout && !busy_ff && !hold_rst; // RULE1 RULE15
  assign read_accept  = is_read && awake && read_ok && !hold_rst; // RULE4 RULE17

  // ---------------------------------------------------------------------------
  // write latch and busy stand-in
  // ---------------------------------------------------------------------------
  wire  unlock   = write_accept && (code_ff == UNLOCK_OPC);
  wire  cyc_go   = write_accept && (code_ff != UNLOCK_OPC) && wl_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wl_ff   <= 1'b0; // RULE18 RULE20
      busy_ff <= 1'b0; // RULE20
    end else begin
      if (unlock) wl_ff <= 1'b1; // RULE22
      else if (cyc_go || hold_rst) wl_ff <= 1'b0;
      if (cyc_go) busy_ff <= 1'b1; // RULE21
      else if (busy_done) busy_ff <= 1'b0; // RULE21
    end
  end
  assign busy_flag        = busy_ff;
  assign write_latch_flag = wl_ff;
  assign sleeping         = (st_ff == PM_SLEEP);
  // deselect idle in PM_STANDBY is standby; a cycle in progress holds it off
  assign standby = awake && sel_n && !busy_ff; // RULE2
endmodule

// [rtl/flash_pm_host.sv]
// host end: sends one 8-bit instruction per request over the serial link
// assumes the link clock is made here by dividing core_clk
module flash_pm_host
  import flash_pm_pkg::*;
#(
  parameter int HALF_CYC  = HALF_SCK_CYC,
  parameter int GUARD_CYC = WAKE_CYC,
  parameter int PWR_CYC   = SELECT_DELAY_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  flash_link_if.host_end  link,
  input  wire logic       req_valid,
  input  wire logic [7:0] req_code,
  output logic            req_ready,
  output logic            done
);
  typedef enum logic [1:0] {H_PWR = 2'b00, H_IDLE = 2'b01, H_SHIFT = 2'b11, H_GUARD = 2'b10} host_state_e;
  host_state_e st_ff;
  logic [7:0]  sh_ff;
  logic [3:0]  bit_ff;
  logic [31:0] cnt_ff;
  logic        sck_ff, sel_ff, done_ff;
  if (HALF_CYC < 2) begin : g_bad_half
    $error("HALF_CYC too small");
  end
  wire cnt_zero = (cnt_ff == '0);
  assign req_ready   = (st_ff == H_IDLE);
  assign done        = done_ff;
  assign link.sel_n  = sel_ff;
  assign link.sclk   = sck_ff;
  assign link.sdi    = sh_ff[7];
  assign link.reset_n = (st_ff != H_PWR); // RULE19
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff   <= H_PWR; // RULE13
      sel_ff  <= 1'b1;
      sck_ff  <= 1'b0;
      sh_ff   <= 8'h00;
      bit_ff  <= 4'h0;
      cnt_ff  <= 32'(PWR_CYC);
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!cnt_zero) cnt_ff <= cnt_ff - 32'h1;
      case (st_ff)
        H_PWR: if (cnt_zero) st_ff <= H_IDLE; // RULE13
        H_IDLE: if (req_valid) begin
          sh_ff  <= req_code;
          sel_ff <= 1'b0;
          bit_ff <= 4'h0;
          cnt_ff <= 32'(HALF_CYC);
          st_ff  <= H_SHIFT;
        end
        H_SHIFT: if (cnt_zero) begin
          cnt_ff <= 32'(HALF_CYC);
          if (bit_ff == BITS_PER_CODE) begin
            sel_ff <= 1'b1; // RULE6 RULE9
            cnt_ff <= 32'(GUARD_CYC);
            st_ff  <= H_GUARD;
          end else if (!sck_ff) sck_ff <= 1'b1;
          else begin
            sck_ff <= 1'b0;
            sh_ff  <= {sh_ff[6:0], 1'b0};
            bit_ff <= bit_ff + 4'h1;
          end
        end
        H_GUARD: if (cnt_zero) begin // RULE11 RULE16
          done_ff <= 1'b1;
          st_ff   <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
endmodule

// [testbench/flash_link_monitor.sv]
// checker for the serial link between host end and flash end
// assumes every link signal is sampled on core_clk; instantiated beside the interface
// ----------------------------------------
// helper counters
// ----------------------------------------
module flash_link_monitor #(
  parameter int GUARD_CYC = 120,
  parameter int PWR_CYC   = 1200
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_ff;
  logic [3:0] rise_ff;
  int         gap_ff;
  int         pwr_ff;
  wire        sclk_rise = sclk && !sclk_ff;

  // gap starts full: the power-up hold already keeps the first frame back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_ff <= 1'b0;
      rise_ff <= 4'h0;
      gap_ff  <= GUARD_CYC;
      pwr_ff  <= 0;
    end else begin
      sclk_ff <= sclk;
      rise_ff <= sel_n ? 4'h0 : (sclk_rise && rise_ff != 4'hf) ? rise_ff + 4'h1 : rise_ff;
      gap_ff  <= !sel_n ? 0 : (gap_ff < GUARD_CYC) ? gap_ff + 1 : gap_ff;
      pwr_ff  <= (!reset_n && pwr_ff < PWR_CYC) ? pwr_ff + 1 : pwr_ff;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence frame_open;
    $fell(sel_n);
  endsequence
  sequence frame_close;
    $rose(sel_n);
  endsequence

  chk_held_unselected: assert property (!reset_n |-> sel_n)
    else $error("link selected during power-up hold");
  chk_pwr_hold: assert property ($rose(reset_n) |-> pwr_ff >= PWR_CYC - 1)
    else $error("power-up hold released too early");
  chk_eight_rises: assert property (frame_close |-> rise_ff == 4'h8)
    else $error("frame closed without exactly eight clock rises");
  chk_frame_bound: assert property (frame_open |-> ##[60:200] frame_close)
    else $error("frame did not close in time");
  chk_guard_gap: assert property (frame_open |-> gap_ff >= GUARD_CYC - 1)
    else $error("reselected before wake delay ran out");
  chk_frame_start: assert property (frame_open |-> !sclk ##1 !sclk)
    else $error("link clock not low at frame start");
  chk_clk_idle: assert property (sel_n [*3] |-> !sclk)
    else $error("link clock moving while deselected");
  chk_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("data changed while link clock high");
endmodule

// [testbench/flash_power_mode_control_bench.sv]
// bench: host end and flash end joined by the link interface
// assumes shortened lockout and hold counts; busy cycles ended by busy_done
module flash_power_mode_control_bench
  import flash_pm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  typedef struct { logic slp; logic bsy; int wr; int rd; } note_s;
  localparam int LOCK_T = 600;
  localparam int HOLD_T = 20;
  logic       core_clk, rst, req_valid, req_ready, done, busy_done;
  logic       sleeping, standby, busy_flag, write_latch_flag, lockout, write_accept, read_accept, read_ok;
  logic [7:0] req_code;
  logic [7:0] wcodes [5] = '{UNLOCK_OPC, REWRITE_OPC, PROGRAM_OPC, PAGE_CLR_OPC, BLOCK_CLR_OPC};
  int         n_errors, samples_checked, wr_total, rd_total, wr_prev, rd_prev, start;
  note_s      notes [$];
  note_s      nt;
  flash_link_if link ();
  flash_pm_host #(.PWR_CYC(HOLD_T)) i_flash_pm_host (.core_clk(core_clk), .rst(rst), .link(link),
    .req_valid(req_valid), .req_code(req_code), .req_ready(req_ready), .done(done));
  flash_pm_dev #(.LOCK_CYC(LOCK_T), .SEL_CYC(HOLD_T)) i_flash_pm_dev (.core_clk(core_clk), .rst(rst),
    .link(link), .busy_done(busy_done), .sleeping(sleeping), .standby(standby), .busy_flag(busy_flag),
    .write_latch_flag(write_latch_flag), .lockout(lockout), .read_ok(read_ok), .write_accept(write_accept),
    .read_accept(read_accept));
  flash_link_monitor #(.GUARD_CYC(WAKE_CYC), .PWR_CYC(HOLD_T)) i_flash_link_monitor (.core_clk(core_clk),
    .rst(rst), .sel_n(link.sel_n), .sclk(link.sclk), .sdi(link.sdi), .reset_n(link.reset_n));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_lvl(ref logic sig, input logic val, input int lim);
    int k;
    k = 0;
    while (sig !== val && k < lim) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= lim) begin
      check("wait bound", 1'b0, 1'b1);
      conclude();
    end
  endtask
  // one request, then a settle gap so the watcher has compared before the next
  task automatic send(input logic [7:0] code, input logic slp, input logic bsy, input int wr, input int rd);
    notes.push_back('{slp, bsy, wr, rd});
    @(negedge core_clk);
    req_code = code;
    req_valid = 1'b1;
    wait_lvl(req_ready, 1'b1, 2000);
    @(negedge core_clk);
    req_valid = 1'b0;
    req_code = 8'($urandom);
    wait_lvl(done, 1'b1, 2000);
    repeat (30) @(negedge core_clk);
  endtask
  // ----------------------------------------
  // watcher: accept pulses counted, state compared a settle time after done
  // ----------------------------------------
  always @(negedge core_clk) begin
    wr_total += int'(write_accept === 1'b1);
    rd_total += int'(read_accept === 1'b1);
  end
  always @(negedge core_clk) begin
    if (done === 1'b1) begin
      repeat (24) @(negedge core_clk);
      if (notes.size() == 0) begin
        check("note queue", 1'b1, 1'b0);
      end else begin
        nt = notes.pop_front();
        check("sleeping", nt.slp, sleeping);
        check("busy_flag", nt.bsy, busy_flag);
        check("write_accept", nt.wr, wr_total - wr_prev);
        check("read_accept", nt.rd, rd_total - rd_prev);
      end
      wr_prev = wr_total;
      rd_prev = rd_total;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {rst, req_valid, busy_done, req_code} = {1'b1, 1'b0, 1'b0, 8'h00};
    {n_errors, samples_checked, wr_total, rd_total, wr_prev, rd_prev} = '0;
    void'($urandom(92260));
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check("standby", 1'b1, standby);
    check("write_latch_flag", 1'b0, write_latch_flag);
    check("lockout", 1'b1, lockout);
    check("read_ok", 1'b0, read_ok);
    send(UNLOCK_OPC, 1'b0, 1'b0, 0, 0);
    send(READ_OPC, 1'b0, 1'b0, 0, 1);
    wait_lvl(lockout, 1'b0, 1000);
    check("read_ok", 1'b1, read_ok);
    send(SLEEP_OPC, 1'b1, 1'b0, 0, 0);
    start = $urandom % 5;
    for (int i = 0; i < 5; i++) send(wcodes[(start + i) % 5], 1'b1, 1'b0, 0, 0);
    send(READ_OPC, 1'b1, 1'b0, 0, 0);
    send(WAKE_OPC, 1'b0, 1'b0, 0, 0);
    send(UNLOCK_OPC, 1'b0, 1'b0, 1, 0);
    check("write_latch_flag", 1'b1, write_latch_flag);
    send(PROGRAM_OPC, 1'b0, 1'b1, 1, 0);
    check("standby", 1'b0, standby);
    send(SLEEP_OPC, 1'b0, 1'b1, 0, 0);
    send(WAKE_OPC, 1'b0, 1'b1, 0, 0);
    busy_done = 1'b1;
    @(negedge core_clk);
    busy_done = 1'b0;
    repeat (4) @(negedge core_clk);
    check("busy_flag", 1'b0, busy_flag);
    check("standby", 1'b1, standby);
    send(SLEEP_OPC, 1'b1, 1'b0, 0, 0);
    rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check("sleeping", 1'b0, sleeping);
    check("standby", 1'b1, standby);
    check("write_latch_flag", 1'b0, write_latch_flag);
    check("lockout", 1'b1, lockout);
    check("read_ok", 1'b0, read_ok);
    conclude();
  end
endmodule
